//--- design/ded_top.sv
// Diagnostic event reporting with microsecond timestamp and fault lamp
// Function
// - A 32-bit microsecond ticker starts at zero and wraps after all ones.
// - The timestamp output holds the ticker's low 16 bits at each event.
// - When enabled, each incoming interrupt comes with diagnostic data.
// - The going interrupt is raised by itself once the fault has cleared.
// - Channel events inside the incoming-to-going window are discarded.
// - The fault lamp is lit from each incoming to the going that follows it.
// - Data flags parameter, overflow, underflow, lost and power faults.
// - Control byte 00h enables and 40h disables incoming diagnostic interrupts.
`timescale 1ns/1ps
`include "ded_cfg.svh"
module ded_top
   import ded_pkg::*;
#(
   parameter int CHANNELS = 2,
   parameter int PRESCALE = `DED_TICK_CYCLES
) (
   input  wire logic                CLOCK,
   input  wire logic                ARST_N,
   input  wire logic [7:0]          DIAG_CTRL,
   input  wire logic                PARAM_ERR,
   input  wire logic [CHANNELS-1:0] RANGE_OVF,
   input  wire logic [CHANNELS-1:0] RANGE_UNF,
   input  wire logic                IRQ_LOST,
   input  wire logic                PWR_FAIL,
   output logic                     DIAG_IRQ_IN,
   output logic                     DIAG_IRQ_OUT,
   output logic [15:0]              EVENT_TIMESTAMP_LOW,
   output logic [4+CHANNELS:0]      DIAG_DATA,
   output logic                     FAULT_INDICATOR_LAMP
);

   localparam int NIN = 3 * CHANNELS + 3;

   ded_tick_if tk ();
   ded_state_e state;

   logic [NIN-1:0]        raw;
   logic [NIN-1:0]        sync1;
   logic [NIN-1:0]        sync2;
   logic [7:0]            ctrl1;
   logic [7:0]            ctrl2;
   logic [CHANNELS-1:0]   ovf;
   logic [CHANNELS-1:0]   unf;
   logic [CHANNELS-1:0]   ch_fault;
   logic [4+CHANNELS:0]   next_data;
   logic                  diag_en;
   logic                  any_fault;
   logic                  raise_in;
   logic                  raise_out;

   // ==========================================================
   // Microsecond time base
   ded_ticker #(
      .PRESCALE (PRESCALE)
   ) u_ticker (
      .clk    (CLOCK),
      .arst_n (ARST_N),
      .tk     (tk)
   );

   // ==========================================================
   // Pin synchronisers; first stage only feeds the second stage
   assign raw = {PWR_FAIL, IRQ_LOST, PARAM_ERR, RANGE_UNF, RANGE_OVF};

   always_ff @(posedge CLOCK or negedge ARST_N) begin
      if (!ARST_N) begin
         sync1 <= '0;
         sync2 <= '0;
      end else begin
         sync1 <= raw;
         sync2 <= sync1;
      end
   end

   // Control byte is static but still arrives from outside the domain
   always_ff @(posedge CLOCK or negedge ARST_N) begin
      if (!ARST_N) begin
         ctrl1 <= `DED_DIAG_DISABLE;
         ctrl2 <= `DED_DIAG_DISABLE;
      end else begin
         ctrl1 <= DIAG_CTRL;
         ctrl2 <= ctrl1;
      end
   end

   // Only the enable code opens the gate; any other byte keeps it shut
   assign diag_en = (ctrl2 == `DED_DIAG_ENABLE);

   assign ovf = sync2[CHANNELS-1:0];
   assign unf = sync2[2*CHANNELS-1:CHANNELS];

   // ==========================================================
   // Per-channel fault summary
   genvar g;
   generate
      for (g = 0; g < CHANNELS; g++) begin : g_chan
         assign ch_fault[g] = ovf[g] | unf[g];
      end
   endgenerate

   // Diagnostic data image as it would be latched right now
   always_comb begin
      next_data                 = '0;
      next_data[`DED_F_PARAM]   = sync2[2*CHANNELS];
      next_data[`DED_F_OVF]     = |ovf;
      next_data[`DED_F_UNF]     = |unf;
      next_data[`DED_F_LOST]    = sync2[2*CHANNELS+1];
      next_data[`DED_F_PWR]     = sync2[2*CHANNELS+2];
      next_data[4+CHANNELS:`DED_F_CHAN] = ch_fault;
   end

   assign any_fault = |sync2;
   assign raise_in  = (state == DED_IDLE) && diag_en && any_fault;
   assign raise_out = (state == DED_ACTIVE) && !any_fault;

   // ==========================================================
   // Event window: one incoming opens it, the clearing closes it.
   // Changes inside the window are ignored, so the data stays frozen.
   always_ff @(posedge CLOCK or negedge ARST_N) begin
      if (!ARST_N) begin
         state <= DED_IDLE;
      end else begin
         case (state)
            DED_IDLE: begin
               if (raise_in) begin
                  state <= DED_ACTIVE;
               end
            end
            DED_ACTIVE: begin
               if (raise_out) begin
                  state <= DED_IDLE;
               end
            end
            default: begin
               state <= DED_IDLE;
            end
         endcase
      end
   end

   // Interrupt pulses, one cycle each
   always_ff @(posedge CLOCK or negedge ARST_N) begin
      if (!ARST_N) begin
         DIAG_IRQ_IN  <= 1'b0;
         DIAG_IRQ_OUT <= 1'b0;
      end else begin
         DIAG_IRQ_IN  <= raise_in;
         DIAG_IRQ_OUT <= raise_out;
      end
   end

   // Timestamp taken at both incoming and going events
   always_ff @(posedge CLOCK or negedge ARST_N) begin
      if (!ARST_N) begin
         EVENT_TIMESTAMP_LOW <= `DED_STAMP_RST;
      end else if (raise_in || raise_out) begin
         EVENT_TIMESTAMP_LOW <= tk.count[`DED_STAMP_MSB:0];
      end
   end

   // Data latched only on incoming; later channel events are dropped
   always_ff @(posedge CLOCK or negedge ARST_N) begin
      if (!ARST_N) begin
         DIAG_DATA <= (5 + CHANNELS)'(`DED_DATA_RST);
      end else if (raise_in) begin
         DIAG_DATA <= next_data;
      end
   end

   // Lamp follows the window, registered with the state change
   always_ff @(posedge CLOCK or negedge ARST_N) begin
      if (!ARST_N) begin
         FAULT_INDICATOR_LAMP <= 1'b0;
      end else if (raise_in) begin
         FAULT_INDICATOR_LAMP <= 1'b1;
      end else if (raise_out) begin
         FAULT_INDICATOR_LAMP <= 1'b0;
      end
   end

   // ==========================================================
   // Assertions
   default clocking cb @(posedge CLOCK); endclocking
   default disable iff (!ARST_N);

   sequence s_incoming;
      raise_in ##1 DIAG_IRQ_IN;
   endsequence

   sequence s_going;
      raise_out ##1 DIAG_IRQ_OUT;
   endsequence

   property p_stamp;
      (DIAG_IRQ_IN || DIAG_IRQ_OUT) |->
         EVENT_TIMESTAMP_LOW == $past(tk.count[`DED_STAMP_MSB:0]);
   endproperty
   a_stamp: assert property (p_stamp)
      else $error("timestamp does not match ticker at event");

   property p_data;
      DIAG_IRQ_IN |-> DIAG_DATA == $past(next_data) && DIAG_DATA != '0;
   endproperty
   a_data: assert property (p_data)
      else $error("incoming interrupt without matching data");

   property p_going;
      // Lamp marks the open window, so later idle cycles cannot match
      s_incoming ##[1:1000] (!any_fault && FAULT_INDICATOR_LAMP) |=>
         DIAG_IRQ_OUT;
   endproperty
   a_going: assert property (p_going)
      else $error("going interrupt missing after fault cleared");

   property p_frozen;
      (state == DED_ACTIVE) && $past(state == DED_ACTIVE) |->
         $stable(DIAG_DATA) && !DIAG_IRQ_IN;
   endproperty
   a_frozen: assert property (p_frozen)
      else $error("channel event stored inside the window");

   property p_lamp;
      s_incoming |-> FAULT_INDICATOR_LAMP throughout
         ((state == DED_ACTIVE) [*1]);
   endproperty
   a_lamp: assert property (p_lamp)
      else $error("fault lamp not lit at incoming interrupt");

   property p_lamp_off;
      s_going |-> !FAULT_INDICATOR_LAMP && state == DED_IDLE;
   endproperty
   a_lamp_off: assert property (p_lamp_off)
      else $error("fault lamp still lit after going interrupt");

   property p_flags;
      DIAG_IRQ_IN |-> DIAG_DATA[`DED_F_OVF] == $past(|ovf) &&
         DIAG_DATA[`DED_F_PWR] == $past(sync2[2*CHANNELS+2]);
   endproperty
   a_flags: assert property (p_flags)
      else $error("fault flags wrong in diagnostic data");

   property p_gate;
      (ctrl2 != `DED_DIAG_ENABLE) |=> !DIAG_IRQ_IN;
   endproperty
   a_gate: assert property (p_gate)
      else $error("incoming interrupt while disabled");

   property p_base;
      tk.tick |=> !tk.tick && $changed(tk.count);
   endproperty
   a_base: assert property (p_base)
      else $error("microsecond tick repeated back to back");

endmodule // ded_top

//--- pkg/ded_cfg.svh
// Timing, encoding and field constants for the diagnostic event block
`ifndef DED_CFG_SVH
`define DED_CFG_SVH

// ==========================================================
// Timing
`define DED_CLK_PERIOD_NS 10
`define DED_TICK_PERIOD_NS 1000
`define DED_TICK_CYCLES (`DED_TICK_PERIOD_NS / `DED_CLK_PERIOD_NS)

// ==========================================================
// Reset values
`define DED_TICKER_RST 32'h0000_0000
`define DED_STAMP_RST 16'h0000
`define DED_DATA_RST 7'h00

// ==========================================================
// Diagnostic interrupt control byte encodings
`define DED_DIAG_ENABLE 8'h00
`define DED_DIAG_DISABLE 8'h40

// ==========================================================
// Diagnostic data field positions and timestamp MSB
`define DED_F_PARAM 0
`define DED_F_OVF 1
`define DED_F_UNF 2
`define DED_F_LOST 3
`define DED_F_PWR 4
`define DED_F_CHAN 5
`define DED_STAMP_MSB 15

`endif

//--- pkg/ded_pkg.sv
// Types shared by the diagnostic event block
package ded_pkg;

   // Gray-coded event window states
   typedef enum logic [1:0] {
      DED_IDLE   = 2'b00,
      DED_ACTIVE = 2'b01
   } ded_state_e;

   typedef logic [31:0] ded_ticker_t;
   typedef logic [15:0] ded_stamp_t;

endpackage

//--- pkg/ded_tick_if.sv
// Carrier for the microsecond ticker between ticker and event logic
`timescale 1ns/1ps
interface ded_tick_if;
   import ded_pkg::*;
   ded_ticker_t count;
   logic        tick;
   modport src (output count, output tick);
   modport snk (input count, input tick);
endinterface

//--- design/ded_ticker.sv
// Microsecond prescaler and free-running 32-bit ticker
`timescale 1ns/1ps
`include "ded_cfg.svh"
module ded_ticker
   import ded_pkg::*;
#(
   parameter int PRESCALE = `DED_TICK_CYCLES
) (
   input wire logic clk,
   input wire logic arst_n,
   ded_tick_if.src  tk
);

   localparam logic [7:0] PRE_LAST = 8'(PRESCALE - 1);

   logic [7:0] pre;

   // ==========================================================
   // Prescaler: fixed divider, never paused by event activity
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         pre     <= 8'h00;
         tk.tick <= 1'b0;
      end else if (pre == PRE_LAST) begin
         pre     <= 8'h00;
         tk.tick <= 1'b1;
      end else begin
         pre     <= pre + 8'h01;
         tk.tick <= 1'b0;
      end
   end

   // ==========================================================
   // Ticker wraps naturally from all ones back to zero
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         tk.count <= `DED_TICKER_RST;
      end else if (tk.tick) begin
         tk.count <= tk.count + 32'h0000_0001;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!arst_n);

   property p_tick_inc;
      tk.tick |=> tk.count == $past(tk.count) + 32'h0000_0001;
   endproperty
   a_tick_inc: assert property (p_tick_inc)
      else $error("ticker did not advance on tick");

   property p_tick_spacing;
      tk.tick |=> (!tk.tick)[*8];
   endproperty
   a_tick_spacing: assert property (p_tick_spacing)
      else $error("microsecond ticks too close together");

   property p_hold_between;
      !tk.tick |=> $stable(tk.count);
   endproperty
   a_hold_between: assert property (p_hold_between)
      else $error("ticker moved without a tick");

endmodule // ded_ticker

//--- tb/ded_coupler_model.sv
// Bus coupler model: writes the control byte and watches event pairing
`timescale 1ns/1ps
module ded_coupler_model (
   input  wire logic       CLOCK,
   input  wire logic       ARST_N,
   input  wire logic [7:0] ctrl_req,
   input  wire logic       irq_in,
   input  wire logic       irq_out,
   input  wire logic [6:0] diag_data,
   output logic      [7:0] diag_ctrl,
   output int              proto_errs
);
   logic open_win;
   int   errs = 0;

   // ==========================================================
   // Control byte starts disabled so no event is requested early
   always @(posedge CLOCK or negedge ARST_N)
      diag_ctrl <= !ARST_N ? 8'h40 : ctrl_req;
   assign proto_errs = errs;

   // ==========================================================
   // Each incoming must carry data and pair with exactly one going
   always @(posedge CLOCK or negedge ARST_N) begin
      if (!ARST_N) begin
         open_win <= 1'b0;
      end else if (irq_in) begin
         if (open_win || diag_data == 7'h00) errs <= errs + 1;
         open_win <= 1'b1;
      end else if (irq_out) begin
         if (!open_win) errs <= errs + 1;
         open_win <= 1'b0;
      end
   end
endmodule // ded_coupler_model

//--- tb/ded_top_bench.sv
// Self-checking bench for the diagnostic event block
`timescale 1ns/1ps
module ded_top_bench;
   import ded_pkg::*;
   localparam int P = 10;  // Short prescale keeps the run brief
   logic       clock = 1'b0;
   logic       arst_n = 1'b0;
   logic [6:0] f = 7'h00;
   logic [7:0] ctrl_req = 8'h00;
   logic [7:0] diag_ctrl;
   logic       irq_in, irq_out, lamp;
   logic [15:0] stamp;
   logic [6:0] data;
   int         proto_errs, errors = 0, checked = 0, cyc;
   int         seed = 32'hc5a849ad;
   logic [31:0] r;
   logic [6:0] s1, s2, m_data;
   logic [7:0] k1, k2;
   logic       win, m_in, m_out;
   logic [15:0] st_a;

   always #5 clock = ~clock;

   ded_top #(.CHANNELS(2), .PRESCALE(P)) u_dut (
      .CLOCK(clock), .ARST_N(arst_n), .DIAG_CTRL(diag_ctrl),
      .PARAM_ERR(f[0]), .RANGE_OVF(f[2:1]), .RANGE_UNF(f[4:3]),
      .IRQ_LOST(f[5]), .PWR_FAIL(f[6]), .DIAG_IRQ_IN(irq_in),
      .DIAG_IRQ_OUT(irq_out), .EVENT_TIMESTAMP_LOW(stamp),
      .DIAG_DATA(data), .FAULT_INDICATOR_LAMP(lamp));

   ded_coupler_model u_cpl (
      .CLOCK(clock), .ARST_N(arst_n), .ctrl_req(ctrl_req),
      .irq_in(irq_in), .irq_out(irq_out), .diag_data(data),
      .diag_ctrl(diag_ctrl), .proto_errs(proto_errs));

   // ==========================================================
   // Reference model; two sync stages, so pins act three edges on
   always @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         {s1, s2, win, m_in, m_out, m_data, st_a} <= '0;
         {k1, k2} <= 16'hffff;
         cyc <= -1; // Registered tick makes the ticker lag one edge
      end else begin
         {s1, s2, k1, k2} <= {f, s1, diag_ctrl, k1};
         cyc <= cyc + 1;
         {m_in, m_out} <= 2'b00;
         if (!win && |s2 && k2 == 8'h00) begin
            {m_in, win} <= 2'b11;
            m_data <= {s2[2:1] | s2[4:3], s2[6], s2[5], |s2[4:3],
                       |s2[2:1], s2[0]};
            st_a <= 16'(cyc / P);
         end else if (win && !(|s2)) begin
            {m_out, win} <= 2'b10;
            st_a <= 16'(cyc / P);
         end
      end
   end

   // ==========================================================
   // Compare and count
   task automatic check(string what, logic [31:0] exp, logic [31:0] seen);
      checked++;
      if (seen !== exp) begin
         errors++;
         $display("FAIL %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // Sampled mid-cycle so the edge's updates have landed
   always @(negedge clock) begin
      if (arst_n) begin
         check("irq_in", 32'(m_in), 32'(irq_in));
         check("irq_out", 32'(m_out), 32'(irq_out));
         check("lamp", 32'(win), 32'(lamp));
         check("data", 32'(m_data), 32'(data));
         check("stamp", 32'(st_a), 32'(stamp));
         check("ticker", 32'(cyc / P), u_dut.tk.count);
      end
   end

   task automatic step(int n);
      repeat (n) @(posedge clock);
   endtask

   // One fault episode; the second fault set lands inside the window
   task automatic episode(logic [6:0] a, logic [6:0] b, logic [7:0] c1,
                          logic [7:0] c2, int hold);
      ctrl_req <= c1;
      step(4);
      f <= a;
      step(hold);
      ctrl_req <= c2;
      f <= b;
      step(hold);
      f <= 7'h00;
      step(8);
   endtask

   task automatic tally_and_finish;
      if (errors == 0 && checked > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   // ==========================================================
   // Main sequence
   initial begin
      step(4);
      arst_n <= 1'b1;
      for (int i = 0; i < 7; i++) begin
         episode(7'(1 << i), 7'(1 << i), 8'h00, 8'h00, 6);
      end
      episode(7'h01, 7'h7e, 8'h00, 8'h40, 10);
      episode(7'h40, 7'h40, 8'h40, 8'h40, 10);
      for (int i = 0; i < 60; i++) begin
         r = $random(seed);
         episode(r[6:0], r[13:7], r[16] ? 8'h00 : r[31:24],
                 r[17] ? 8'h00 : 8'h40, 3 + int'(r[21:18]));
      end
      // Reset in mid-window must close it and restart the ticker
      f <= 7'h10;
      ctrl_req <= 8'h00;
      step(6);
      arst_n <= 1'b0;
      step(3);
      arst_n <= 1'b1;
      f <= 7'h00;
      step(P * 30);
      check("pairing", 32'h0, 32'(proto_errs));
      tally_and_finish;
   end

   // Hang guard, well beyond the few thousand cycles expected
   initial begin
      #(50000 * 10);
      errors++;
      tally_and_finish;
   end
endmodule // ded_top_bench
